// ### design/stw_channel.v
// two-wire mode serial channel: avalon slave, condition engine, bit engine
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`include "stw_regs.vh"

// ***********************************************
// Overview of operation
// - two-wire when mode 010b and select set
// - master start request makes start condition
// - master restart request makes repeated start
// - master stop request makes stop condition
// - output select gates conditions onto pins
// - ack value driven when ack output enabled
// - master releases clock after stop detected
// - slave holds clock low after 9th
// - data line output delayed by field
// - condition interrupt on bus condition detect
// - transmit interrupt timing by select, phase
// - receive interrupt timing by select only
// - receive buffer transfer points by select, phase
// - channel 2 data pin always open drain
// - detect start and stop from pin levels
// - busy flag tells start from stop
// ***********************************************
module stw_channel #(
  parameter CHANNEL = 0
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        clock_line_pin_in,
  output wire        clock_line_pin_out,
  output wire        clock_line_pin_oe,
  input  wire        data_line_pin_in,
  output wire        data_line_pin_out,
  output wire        data_line_pin_oe,
  output reg         cond_irq,
  output reg         tx_irq,
  output reg         rx_irq
);

  localparam [4:0] M_IDLE    = 5'b00001;
  localparam [4:0] M_START   = 5'b00010;
  localparam [4:0] M_RESTART = 5'b00100;
  localparam [4:0] M_XFER    = 5'b01000;
  localparam [4:0] M_STOP    = 5'b10000;
  localparam integer M_QTR_INT = `STW_QTR_CYCLES - 1;
  localparam [7:0] M_QTR_LAST = M_QTR_INT[7:0];
  // channel 2 has no open-drain select bit; it reads as zero
  localparam [7:0] MODE_MASK = (CHANNEL == 2) ? 8'h7f : 8'hff;

  function [7:0] masked;
    input [7:0] old;
    input [7:0] wdata;
    input [7:0] mask;
    begin
      masked = (old & ~mask) | (wdata & mask);
    end
  endfunction

  reg  [7:0]  mode_ctrl;
  reg  [7:0]  two_wire_delay_phase_ctrl;
  reg  [7:0]  two_wire_condition_ack_ctrl;
  reg  [7:0]  irq_factor_select_two;
  reg  [7:0]  serial_shared_ctrl;
  reg         bus_busy_flag;
  reg         start_seen;
  reg         stop_seen;
  reg  [8:0]  rx_buffer;
  reg  [7:0]  tx_byte;
  reg         bus_ack;
  reg  [31:0] next_readdata;
  reg         scl_q;
  reg         sda_q;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  rx_shift;
  reg         ack_bit;
  reg         data_bit;
  reg  [7:0]  dly;
  reg         hold_scl;
  reg         scl_free;
  reg  [4:0]  m_state;
  reg  [1:0]  m_phase;
  reg  [3:0]  m_bits;
  reg  [7:0]  m_qcnt;
  reg         m_owned;
  reg         xfer_pend;
  reg         m_scl_low;
  reg         m_sda_low;

  // ***********************************************
  // field decode
  // ***********************************************
  wire [2:0] serial_mode_field       = mode_ctrl[`STW_MODE_SMD_HI:`STW_MODE_SMD_LO];
  wire       two_wire_mode_select    = mode_ctrl[`STW_MODE_IIC];
  wire       two_wire_irq_select     = mode_ctrl[`STW_MODE_IRQSEL];
  wire       clock_polarity_select   = mode_ctrl[`STW_MODE_CLOCK_POLARITY_SELECT];
  wire       master                  = mode_ctrl[`STW_MODE_MASTER];
  wire       open_drain_select       = mode_ctrl[`STW_MODE_OPEN_DRAIN];
  wire       clock_phase_delay       = two_wire_delay_phase_ctrl[`STW_DP_CLOCK_PHASE_DELAY];
  wire [2:0] data_delay_amount       = two_wire_delay_phase_ctrl[`STW_DP_DL_HI:`STW_DP_DL_LO];
  wire       start_request           = two_wire_condition_ack_ctrl[`STW_CA_START];
  wire       restart_request         = two_wire_condition_ack_ctrl[`STW_CA_RESTART];
  wire       stop_request            = two_wire_condition_ack_ctrl[`STW_CA_STOP];
  wire       condition_output_select = two_wire_condition_ack_ctrl[`STW_CA_OUTSEL];
  wire       ack_value_select        = two_wire_condition_ack_ctrl[`STW_CA_ACKVAL];
  wire       ack_output_enable       = two_wire_condition_ack_ctrl[`STW_CA_ACKEN];
  wire       clock_release_on_stop   = two_wire_condition_ack_ctrl[`STW_CA_CLKREL];
  wire       ninth_clock_low_hold    = two_wire_condition_ack_ctrl[`STW_CA_HOLD9];

  wire iic_on = (serial_mode_field == `STW_SMD_TWO_WIRE) & two_wire_mode_select;
  wire cs_on  = (serial_mode_field == `STW_SMD_CLK_SYNC) & ~two_wire_mode_select;

  // ***********************************************
  // avalon slave: one wait state per access
  // ***********************************************
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  wire       wr_go = avs_write & bus_ack & avs_byteenable[0];
  wire [2:0] idx   = avs_address[4:2];
  wire [7:0] wd    = avs_writedata[7:0];
  wire       tx_wr = wr_go & (idx == `STW_IDX_TX_DATA);

  always @* begin
    next_readdata = 32'h0000_0000;
    case (idx)
      `STW_IDX_MODE:        next_readdata[7:0] = mode_ctrl;
      `STW_IDX_DELAY_PHASE: next_readdata[7:0] = two_wire_delay_phase_ctrl;
      `STW_IDX_COND_ACK:    next_readdata[7:0] = two_wire_condition_ack_ctrl;
      `STW_IDX_IRQ_FACTOR:  next_readdata[7:0] = irq_factor_select_two;
      `STW_IDX_SHARED:      next_readdata[7:0] = serial_shared_ctrl;
      `STW_IDX_STATUS:      next_readdata[3:0] = {ack_bit, stop_seen, start_seen, bus_busy_flag};
      `STW_IDX_RX_BUFFER:   next_readdata[8:0] = rx_buffer;
      `STW_IDX_TX_DATA:     next_readdata[7:0] = tx_byte;
      default:              next_readdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      bus_ack      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
      if (avs_read & ~bus_ack)
        avs_readdata <= next_readdata;
    end
  end

  // ***********************************************
  // pin edges and condition detection
  // ***********************************************
  wire scl_rise  = clock_line_pin_in & ~scl_q;
  wire scl_fall  = ~clock_line_pin_in & scl_q;
  wire start_det = iic_on & clock_line_pin_in & scl_q & sda_q & ~data_line_pin_in;
  wire stop_det  = iic_on & clock_line_pin_in & scl_q & ~sda_q & data_line_pin_in;
  wire eighth_fall = iic_on & scl_fall & (bit_cnt == 4'd8);
  wire nine_rise   = iic_on & scl_rise & (bit_cnt == 4'd8);
  wire nine_fall   = iic_on & scl_fall & (bit_cnt == 4'd9);
  wire cs_edge     = cs_on & (clock_polarity_select ? scl_fall : scl_rise);

  // ***********************************************
  // master condition and clock engine
  // ***********************************************
  wire m_stall = (m_state == M_XFER) & (m_phase == 2'd2) & ~clock_line_pin_in;
  wire m_done  = (m_state != M_IDLE) & ~m_stall & (m_qcnt == M_QTR_LAST) & (m_phase == 2'd3);
  wire can_cond = iic_on & master & condition_output_select;
  wire cond_active = |(m_state & (M_START | M_RESTART | M_STOP));

  always @* begin
    m_scl_low = 1'b0;
    m_sda_low = 1'b0;
    case (m_state)
      M_IDLE: m_scl_low = m_owned;
      M_START: begin
        m_sda_low = 1'b1;
        m_scl_low = (m_phase == 2'd3);
      end
      M_RESTART: begin
        m_scl_low = (m_phase == 2'd0) | (m_phase == 2'd3);
        m_sda_low = m_phase[1];
      end
      M_XFER: m_scl_low = ~m_phase[1];
      M_STOP: begin
        m_scl_low = (m_phase == 2'd0);
        m_sda_low = ~m_phase[1];
      end
      default: begin
        m_scl_low = 1'b0;
        m_sda_low = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      m_state   <= M_IDLE;
      m_phase   <= 2'd0;
      m_bits    <= 4'd0;
      m_qcnt    <= 8'h00;
      m_owned   <= 1'b0;
      xfer_pend <= 1'b0;
      scl_free  <= 1'b0;
    end else begin
      if (tx_wr & master)
        xfer_pend <= 1'b1;
      if (stop_det & master & clock_release_on_stop)
        scl_free <= 1'b1;
      if (m_state == M_IDLE) begin
        m_qcnt  <= 8'h00;
        m_phase <= 2'd0;
        m_bits  <= 4'd0;
        if (!iic_on | !master) begin
          m_owned <= 1'b0;
        end else if (can_cond & stop_request & m_owned) begin
          m_state <= M_STOP;
        end else if (can_cond & restart_request & m_owned) begin
          m_state <= M_RESTART;
        end else if (can_cond & start_request & ~m_owned & ~bus_busy_flag) begin
          m_state  <= M_START;
          scl_free <= 1'b0;
        end else if (xfer_pend & m_owned) begin
          m_state   <= M_XFER;
          xfer_pend <= tx_wr;
        end
      end else if (!iic_on) begin
        m_state <= M_IDLE;
        m_owned <= 1'b0;
      end else if (!m_stall) begin
        if (m_qcnt == M_QTR_LAST) begin
          m_qcnt  <= 8'h00;
          m_phase <= m_phase + 2'd1;
          if (m_phase == 2'd3) begin
            case (m_state)
              M_START:   m_owned <= 1'b1;
              M_STOP:    m_owned <= 1'b0;
              M_XFER:    m_bits  <= m_bits + 4'd1;
              default:   m_owned <= m_owned;
            endcase
            if ((m_state != M_XFER) | (m_bits == 4'd8))
              m_state <= M_IDLE;
          end
        end else begin
          m_qcnt <= m_qcnt + 8'd1;
        end
      end
    end
  end

  // ***********************************************
  // register file; a request bit clears when its condition is done
  // ***********************************************
  always @(posedge clk) begin
    if (!rstn) begin
      mode_ctrl                   <= `STW_RST_REG;
      two_wire_delay_phase_ctrl   <= `STW_RST_REG;
      two_wire_condition_ack_ctrl <= `STW_RST_REG;
      irq_factor_select_two       <= `STW_RST_REG;
      serial_shared_ctrl          <= `STW_RST_REG;
      start_seen                  <= 1'b0;
      stop_seen                   <= 1'b0;
      bus_busy_flag               <= 1'b0;
    end else begin
      if (m_done & (m_state == M_START))
        two_wire_condition_ack_ctrl[`STW_CA_START] <= 1'b0;
      if (m_done & (m_state == M_RESTART))
        two_wire_condition_ack_ctrl[`STW_CA_RESTART] <= 1'b0;
      if (m_done & (m_state == M_STOP))
        two_wire_condition_ack_ctrl[`STW_CA_STOP] <= 1'b0;
      if (wr_go) begin
        case (idx)
          `STW_IDX_MODE:        mode_ctrl <= wd & MODE_MASK;
          `STW_IDX_DELAY_PHASE: two_wire_delay_phase_ctrl <=
                                  masked(two_wire_delay_phase_ctrl, wd, `STW_MASK_DELAY);
          `STW_IDX_COND_ACK:    two_wire_condition_ack_ctrl <= wd;
          `STW_IDX_IRQ_FACTOR:  irq_factor_select_two <=
                                  masked(irq_factor_select_two, wd, `STW_MASK_IRQ_FACTOR);
          `STW_IDX_SHARED:      serial_shared_ctrl <=
                                  masked(serial_shared_ctrl, wd, `STW_MASK_SHARED);
          `STW_IDX_STATUS: begin
            if (wd[`STW_ST_START_SEEN])
              start_seen <= 1'b0;
            if (wd[`STW_ST_STOP_SEEN])
              stop_seen <= 1'b0;
          end
          default: start_seen <= start_seen;
        endcase
      end
      // detection after the clear so a coincident event survives
      if (start_det) begin
        start_seen    <= 1'b1;
        bus_busy_flag <= 1'b1;
      end
      if (stop_det) begin
        stop_seen     <= 1'b1;
        bus_busy_flag <= 1'b0;
      end
      if (!iic_on)
        bus_busy_flag <= 1'b0;
    end
  end

  // ***********************************************
  // bit engine: shift, receive buffer, interrupt sources
  // ***********************************************
  wire ack9 = ack_output_enable ? ack_value_select : 1'b1;

  always @(posedge clk) begin
    if (!rstn) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      bit_cnt   <= 4'd0;
      rx_shift  <= 8'h00;
      rx_buffer <= 9'h000;
      ack_bit   <= 1'b0;
      tx_byte   <= `STW_RST_TX_BYTE;
      data_bit  <= 1'b1;
      hold_scl  <= 1'b0;
      cond_irq  <= 1'b0;
      tx_irq    <= 1'b0;
      rx_irq    <= 1'b0;
    end else begin
      scl_q    <= clock_line_pin_in;
      sda_q    <= data_line_pin_in;
      cond_irq <= start_det | stop_det;
      tx_irq   <= 1'b0;
      rx_irq   <= 1'b0;
      if (start_det | stop_det | ~(iic_on | cs_on)) begin
        bit_cnt <= 4'd0;
      end else if (cs_edge) begin
        rx_shift <= {rx_shift[6:0], data_line_pin_in};
        if (bit_cnt == 4'd7) begin
          bit_cnt   <= 4'd0;
          rx_buffer <= {1'b0, rx_shift[6:0], data_line_pin_in};
          rx_irq    <= 1'b1;
          tx_irq    <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 4'd1;
        end
      end else if (iic_on & scl_rise) begin
        if (bit_cnt < 4'd8)
          rx_shift <= {rx_shift[6:0], data_line_pin_in};
        if (bit_cnt < 4'd9)
          bit_cnt <= bit_cnt + 4'd1;
      end else if (iic_on & scl_fall) begin
        if (bit_cnt < 4'd8)
          data_bit <= tx_byte[~bit_cnt[2:0]];
        else if (bit_cnt == 4'd8)
          data_bit <= ack9;
        else begin
          data_bit <= 1'b1;
          tx_byte  <= `STW_RST_TX_BYTE;
          bit_cnt  <= 4'd0;
        end
      end
      if (nine_rise) begin
        ack_bit <= data_line_pin_in;
        if (!two_wire_irq_select | clock_phase_delay)
          rx_buffer <= {data_line_pin_in, rx_shift};
        if (!two_wire_irq_select) begin
          tx_irq <= data_line_pin_in;
          rx_irq <= ~data_line_pin_in;
        end else if (!clock_phase_delay) begin
          tx_irq <= 1'b1;
        end
      end
      if (eighth_fall & two_wire_irq_select) begin
        rx_irq <= 1'b1;
        if (clock_phase_delay)
          rx_buffer <= {rx_shift[0], 1'b0, rx_shift[7:1]};
        else
          rx_buffer <= {1'b0, rx_shift};
      end
      if (nine_fall & two_wire_irq_select & clock_phase_delay)
        tx_irq <= 1'b1;
      // slave clock stretch until software reloads data or drops the hold
      if (nine_fall & ~master & ninth_clock_low_hold)
        hold_scl <= 1'b1;
      if (tx_wr | ~ninth_clock_low_hold | master)
        hold_scl <= 1'b0;
      if (tx_wr) begin
        tx_byte <= wd;
        if ((bit_cnt == 4'd0) & ~clock_line_pin_in)
          data_bit <= wd[7];
      end
    end
  end

  // ***********************************************
  // data delay line and pin drivers
  // ***********************************************
  always @(posedge clk) begin
    if (!rstn)
      dly <= 8'hff;
    else
      dly <= {dly[6:0], data_bit};
  end

  wire data_lvl = (data_delay_amount == 3'd0) ? data_bit : dly[data_delay_amount - 3'd1];
  wire sda_lvl  = ~iic_on ? 1'b1 : (cond_active ? ~m_sda_low : data_lvl);
  wire open_drain = (CHANNEL == 2) | open_drain_select;
  wire scl_drive_low = iic_on & ((master & m_scl_low & ~scl_free) | (~master & hold_scl));

  assign clock_line_pin_out = 1'b0;
  assign clock_line_pin_oe  = scl_drive_low;
  assign data_line_pin_out  = open_drain ? 1'b0 : sda_lvl;
  assign data_line_pin_oe   = open_drain ? ~sda_lvl : iic_on;

endmodule // stw_channel

// ### design/stw_regs.vh
// register map, field positions, reset values and timing of the two-wire channel
`ifndef STW_REGS_VH
`define STW_REGS_VH

// ***********************************************
// word indices (byte address = 4 * index)
// ***********************************************
`define STW_IDX_MODE        3'h0
`define STW_IDX_DELAY_PHASE 3'h1
`define STW_IDX_COND_ACK    3'h2
`define STW_IDX_IRQ_FACTOR  3'h3
`define STW_IDX_SHARED      3'h4
`define STW_IDX_STATUS      3'h5
`define STW_IDX_RX_BUFFER   3'h6
`define STW_IDX_TX_DATA     3'h7

// ***********************************************
// field positions
// ***********************************************
`define STW_MODE_SMD_HI     2
`define STW_MODE_SMD_LO     0
`define STW_MODE_IIC        3
`define STW_MODE_IRQSEL     4
`define STW_MODE_CLOCK_POLARITY_SELECT      5
`define STW_MODE_MASTER     6
`define STW_MODE_OPEN_DRAIN 7
`define STW_DP_CLOCK_PHASE_DELAY         1
`define STW_DP_DL_HI        7
`define STW_DP_DL_LO        5
`define STW_CA_START        0
`define STW_CA_RESTART      1
`define STW_CA_STOP         2
`define STW_CA_OUTSEL       3
`define STW_CA_ACKVAL       4
`define STW_CA_ACKEN        5
`define STW_CA_CLKREL       6
`define STW_CA_HOLD9        7
`define STW_ST_BUSY         0
`define STW_ST_START_SEEN   1
`define STW_ST_STOP_SEEN    2
`define STW_ST_LAST_ACK     3

// ***********************************************
// encodings, write masks, reset values
// ***********************************************
`define STW_SMD_TWO_WIRE    3'h2
`define STW_SMD_CLK_SYNC    3'h1
`define STW_MASK_DELAY      8'he2
`define STW_MASK_IRQ_FACTOR 8'hc0
`define STW_MASK_SHARED     8'h03
`define STW_RST_REG         8'h00
`define STW_RST_TX_BYTE     8'hff

// ***********************************************
// timing
// ***********************************************
`define STW_CLK_NS          10
`define STW_QTR_NS          2500
`define STW_QTR_CYCLES      ((`STW_QTR_NS + `STW_CLK_NS - 1) / `STW_CLK_NS)

`endif

// ### tb/stw_bus_peer.sv
// two-wire bus peer: slave receiver with acknowledge, plus raw line pulls
`timescale 1ns/1ns
module stw_bus_peer (
  input  wire       clk,
  input  wire       scl,
  input  wire       sda,
  input  wire       ack_low,
  input  wire       raw_scl_low,
  input  wire       raw_sda_low,
  output wire       scl_oe,
  output wire       sda_oe,
  output reg  [7:0] rx_byte
);
  reg       scl_q = 1'b1;
  reg       sda_q = 1'b1;
  reg       ack_drv = 1'b0;
  reg [3:0] cnt = 4'h0;
  assign scl_oe = raw_scl_low;
  assign sda_oe = raw_sda_low | ack_drv;
  initial rx_byte = 8'h00;
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl_q && scl && sda_q != sda) begin
      cnt <= 4'h0;
      ack_drv <= 1'b0;
    end else if (scl && !scl_q) begin
      if (cnt < 4'h8)
        rx_byte <= {rx_byte[6:0], sda};
      if (cnt != 4'hf)
        cnt <= cnt + 4'h1;
    end else if (!scl && scl_q) begin
      // data line only moves while the clock is low, never forming a condition
      ack_drv <= (cnt == 4'h8) && ack_low;
    end
  end
endmodule // stw_bus_peer

// ### tb/stw_channel_properties.sv
// concurrent checks on the two-wire channel ports
`timescale 1ns/1ns
module stw_channel_props (
  input wire clk,
  input wire rstn,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire clock_line_pin_in,
  input wire clock_line_pin_out,
  input wire clock_line_pin_oe,
  input wire data_line_pin_in,
  input wire data_line_pin_oe,
  input wire cond_irq,
  input wire tx_irq,
  input wire rx_irq
);
  reg       scl_q;
  reg       sda_q;
  reg       rst_q;
  reg [3:0] bits;
  wire      cond_ev = scl_q && clock_line_pin_in && (sda_q != data_line_pin_in);
  // ***********************************************
  // clock rises counted since the last condition
  // ***********************************************
  always @(posedge clk) begin
    scl_q <= clock_line_pin_in;
    sda_q <= data_line_pin_in;
    rst_q <= !rstn;
    if (!rstn || cond_ev)
      bits <= 4'h0;
    else if (clock_line_pin_in && !scl_q && bits != 4'hf)
      bits <= bits + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_start;
    scl_q && clock_line_pin_in && sda_q && !data_line_pin_in;
  endsequence
  sequence s_stop;
    scl_q && clock_line_pin_in && !sda_q && data_line_pin_in;
  endsequence
  a_start_irq: assert property (s_start |-> ##[1:3] cond_irq)
    else $error("start seen without condition pulse");
  a_stop_irq: assert property (s_stop |-> ##[1:3] cond_irq)
    else $error("stop seen without condition pulse");
  a_cond_cause: assert property (cond_irq |-> $past(cond_ev, 1) || $past(cond_ev, 2))
    else $error("condition pulse without bus condition");
  a_cond_pulse: assert property (cond_irq |=> !cond_irq)
    else $error("condition pulse longer than one cycle");
  a_data_pulse: assert property ((tx_irq || rx_irq) |=> !(tx_irq || rx_irq))
    else $error("data interrupt longer than one cycle");
  a_irq_after_bits: assert property ((tx_irq || rx_irq) |-> bits >= 4'h8)
    else $error("data interrupt before the eighth clock");
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request answered in its first cycle");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_reset_quiet: assert property (rst_q |-> !clock_line_pin_oe && !data_line_pin_oe)
    else $error("pins driven right after reset");
  a_clock_open_drain: assert property (clock_line_pin_out == 1'b0)
    else $error("clock line output not low");
endmodule // stw_channel_props

bind stw_channel stw_channel_props stw_channel_props_i (
  .clk(clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .clock_line_pin_in(clock_line_pin_in),
  .clock_line_pin_out(clock_line_pin_out), .clock_line_pin_oe(clock_line_pin_oe),
  .data_line_pin_in(data_line_pin_in), .data_line_pin_oe(data_line_pin_oe),
  .cond_irq(cond_irq), .tx_irq(tx_irq), .rx_irq(rx_irq)
);

// ### tb/testbench.sv
// self-checking bench for the two-wire channel
`timescale 1ns/1ns
`include "stw_regs.vh"
module testbench;
  reg         clk, rstn, avs_read, avs_write, ack_low, raw_scl_low, raw_sda_low;
  reg  [4:0]  avs_address;
  reg  [31:0] avs_writedata, q;
  reg  [3:0]  avs_byteenable;
  reg  [7:0]  d;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, scl_oe, scl_out, sda_oe, sda_out, p_scl_oe, p_sda_oe;
  wire        cond_irq, tx_irq, rx_irq;
  wire [7:0]  p_byte;
  // pull-ups on both lines
  wire        scl = !(scl_oe | p_scl_oe);
  wire        sda = !((sda_oe & !sda_out) | p_sda_oe);
  integer     bad_count, total_checks, seed, n_cond, n_tx, n_rx, i, t_tx, t_rx;
  stw_channel stw_channel_i (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .clock_line_pin_in(scl), .clock_line_pin_out(scl_out),
    .clock_line_pin_oe(scl_oe), .data_line_pin_in(sda), .data_line_pin_out(sda_out),
    .data_line_pin_oe(sda_oe), .cond_irq(cond_irq), .tx_irq(tx_irq), .rx_irq(rx_irq));
  stw_bus_peer stw_bus_peer_i (.clk(clk), .scl(scl), .sda(sda), .ack_low(ack_low),
    .raw_scl_low(raw_scl_low), .raw_sda_low(raw_sda_low), .scl_oe(p_scl_oe),
    .sda_oe(p_sda_oe), .rx_byte(p_byte));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cond_irq === 1'b1) n_cond = n_cond + 1;
    if (tx_irq === 1'b1) n_tx = n_tx + 1;
    if (rx_irq === 1'b1) n_rx = n_rx + 1;
  end
  task chk(input [8*12-1:0] nm, input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task bus(input rd, input [2:0] idx, input [7:0] wd);
    integer n;
    begin
      @(posedge clk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, wd};
      n = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= 50)
        bad_count = bad_count + 1;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task wait_clear(input [7:0] m);
    integer k;
    begin
      k = 0;
      bus(1, `STW_IDX_COND_ACK, 8'h00);
      while ((q[7:0] & m) != 8'h00 && k < 200) begin
        repeat (20) @(posedge clk);
        bus(1, `STW_IDX_COND_ACK, 8'h00);
        k = k + 1;
      end
      chk("req_clear", q[7:0] & m, 0);
    end
  endtask
  // one bit clocked by the bench acting as bus master
  task raw_bit(input b);
    begin
      raw_sda_low <= !b;
      repeat (20) @(posedge clk);
      raw_scl_low <= 1'b0;
      repeat (20) @(posedge clk);
      raw_scl_low <= 1'b1;
      repeat (20) @(posedge clk);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    bad_count = bad_count + 1;
    end_of_test;
  end
  initial begin
    seed = 32'h0964;
    {bad_count, total_checks, n_cond, n_tx, n_rx} = 0;
    {rstn, avs_read, avs_write, ack_low, raw_scl_low, raw_sda_low} = 6'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // ***********************************************
    // reset values and write masks
    // ***********************************************
    for (i = 0; i < 7; i = i + 1) begin
      bus(1, i[2:0], 8'h00);
      chk("reset_val", q, 0);
    end
    d = $random(seed);
    bus(0, `STW_IDX_DELAY_PHASE, d);
    bus(1, `STW_IDX_DELAY_PHASE, 8'h00);
    chk("delay_mask", q, d & `STW_MASK_DELAY);
    avs_byteenable <= 4'h0;
    bus(0, `STW_IDX_DELAY_PHASE, ~d);
    avs_byteenable <= 4'h1;
    bus(1, `STW_IDX_DELAY_PHASE, 8'h00);
    chk("byte_enable", q, d & `STW_MASK_DELAY);
    bus(0, `STW_IDX_DELAY_PHASE, 8'h00);
    bus(0, `STW_IDX_SHARED, d);
    bus(1, `STW_IDX_SHARED, 8'h00);
    chk("shared_mask", q, d & `STW_MASK_SHARED);
    bus(0, `STW_IDX_SHARED, 8'h00);
    bus(0, `STW_IDX_IRQ_FACTOR, 8'hc0);
    bus(1, `STW_IDX_IRQ_FACTOR, 8'h00);
    chk("irq_factor", q, 8'hc0);
    $display("register test done");
    // ***********************************************
    // slave: receive a byte, hold clock after the 9th
    // ***********************************************
    bus(0, `STW_IDX_MODE, 8'h8a);
    bus(0, `STW_IDX_COND_ACK, 8'ha0);
    raw_sda_low <= 1'b1;
    repeat (20) @(posedge clk);
    chk("start_irq", n_cond, 1);
    bus(1, `STW_IDX_STATUS, 8'h00);
    chk("busy_start", q[1:0], 2'b11);
    raw_scl_low <= 1'b1;
    repeat (20) @(posedge clk);
    d = $random(seed);
    for (i = 7; i >= 0; i = i - 1)
      raw_bit(d[i]);
    raw_bit(1'b1);
    raw_scl_low <= 1'b0;
    raw_sda_low <= 1'b1;
    repeat (20) @(posedge clk);
    chk("scl_hold", scl, 0);
    bus(1, `STW_IDX_RX_BUFFER, 8'h00);
    chk("slave_rx", q, {1'b0, d});
    chk("slave_tx_irq", n_tx, 0);
    chk("slave_rx_irq", n_rx, 1);
    bus(0, `STW_IDX_COND_ACK, 8'h00);
    repeat (20) @(posedge clk);
    chk("scl_free", scl, 1);
    raw_sda_low <= 1'b0;
    repeat (20) @(posedge clk);
    chk("stop_irq", n_cond, 2);
    bus(1, `STW_IDX_STATUS, 8'h00);
    chk("busy_stop", q[0], 0);
    chk("slave_ack", q[3], 0);
    $display("slave test done");
    // ***********************************************
    // master: start or restart, byte out, peer ack or nack
    // ***********************************************
    for (i = 0; i < 3; i = i + 1) begin
      ack_low <= (i != 1);
      bus(0, `STW_IDX_MODE, (i == 2) ? 8'hda : 8'hca);
      bus(0, `STW_IDX_COND_ACK, (i == 0) ? 8'h09 : 8'h0a);
      wait_clear(8'h03);
      chk("cond_count", n_cond, 3 + i);
      t_tx = n_tx;
      t_rx = n_rx;
      d = $random(seed);
      bus(0, `STW_IDX_TX_DATA, d);
      repeat (9300) @(posedge clk);
      chk("peer_byte", p_byte, d);
      bus(1, `STW_IDX_RX_BUFFER, 8'h00);
      chk("master_rx", q, (i == 2) ? {1'b0, d} : {!ack_low, d});
      chk("tx_irq", n_tx - t_tx, (i == 2) ? 1 : !ack_low);
      chk("rx_irq", n_rx - t_rx, (i == 2) ? 1 : ack_low);
    end
    bus(0, `STW_IDX_COND_ACK, 8'h0c);
    wait_clear(8'h04);
    bus(1, `STW_IDX_STATUS, 8'h00);
    chk("busy_end", q[0], 0);
    chk("lines_idle", {scl, sda}, 2'b11);
    chk("cond_total", n_cond, 6);
    $display("master test done");
    bus(0, `STW_IDX_MODE, 8'h01);
    t_tx = n_tx;
    t_rx = n_rx;
    raw_scl_low <= 1'b1;
    repeat (20) @(posedge clk);
    for (i = 7; i >= 0; i = i - 1)
      raw_bit(d[i]);
    bus(1, `STW_IDX_RX_BUFFER, 8'h00);
    chk("sync_rx", q, {1'b0, d});
    chk("sync_tx", n_tx - t_tx, 1);
    chk("sync_rx_irq", n_rx - t_rx, 1);
    $display("clock sync test done");
    end_of_test;
  end
endmodule // testbench
